// ===== inc/jtag_route_pkg.sv
// Shared constants and carriers for the scan path router
package jtag_route_pkg;

  // ==========================================================
  // Chain layout
  localparam int N_CFG = 6;
  localparam int N_DBG = 3;
  // Config chain order: tile, southbridge, cfg pld, cs pld, nb, cpu bscan
  localparam int CFG_TILE = 0;
  localparam int CFG_CPU_BSCAN = 5;
  // Debug chain order: tile, southbridge, cpu debug unit
  localparam int DBG_TILE = 0;
  localparam int DBG_SB = 1;
  localparam int DBG_CPU = 2;

  // ==========================================================
  // Register port
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h00;
  localparam logic [AW-1:0] ADDR_CTRL = 8'h04;
  localparam int ST_MODE_CFG = 0;
  localparam int ST_PROBE = 1;
  localparam int ST_USB_EN = 2;
  localparam int ST_CAPTURED = 3;
  localparam int CT_USB_ALLOW = 0;
  localparam logic CTRL_USB_ALLOW_RST = 1'h1;

  // ==========================================================
  // Timing
  localparam logic [1:0] SYNC_FILL = 2'h2;

  typedef struct packed {
    logic tms;
    logic tdi;
  } jtag_s;

  localparam jtag_s JTAG_IDLE = '{tms: 1'h1, tdi: 1'h0};

endpackage

// ===== src/jtag_scan_path_router.sv
// Scan path router: debug or configuration chain selected by mode switch
`timescale 1ns/1ps

// Functional notes
// - Switch off at power-up selects debug mode
// - Debug mode keeps mode LEDs off
// - Debug signals pass through processor chip
// - Debug chain: tile, southbridge, processor debug
// - Debug mode routes analyzer through tile cfg
// - Debug mode makes FPGAs load from flash
// - Switch on at power-up selects config mode
// - Config mode lights mode LEDs everywhere
// - Config chain: tile, sb, pld, pld, nb, bscan
// - Config mode drops processor debug, adds bscan
// - Rear/daughter debugger never reaches config chain
// - Config driven by baseboard JTAG or USB
// - Baseboard JTAG never reaches debug chain
// - Rear debugger drives daughterboard debug chain
// - Baseboard probe present disables USB port
// - USB bridge drives internal config JTAG
module jtag_scan_path_router (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck_link,
  input wire logic cfg_switch_on,
  input wire logic bb_probe_present,
  input wire logic [jtag_route_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic led_front_ff,
  output logic led_tile_ff,
  output logic fpga_flash_load_ff,
  output logic usb_cfg_en_ff,
  input wire jtag_route_pkg::jtag_s dbg_in,
  output logic dbg_tdo_ff,
  input wire jtag_route_pkg::jtag_s bb_in,
  output logic bb_tdo_ff,
  input wire jtag_route_pkg::jtag_s usb_in,
  output logic usb_tdo_ff,
  input wire jtag_route_pkg::jtag_s ela_in,
  output logic ela_tdo_ff,
  output jtag_route_pkg::jtag_s [jtag_route_pkg::N_DBG-1:0] dbg_seg_ff,
  input wire logic [jtag_route_pkg::N_DBG-1:0] dbg_seg_tdo,
  output jtag_route_pkg::jtag_s [jtag_route_pkg::N_CFG-1:0] cfg_seg_ff,
  input wire logic [jtag_route_pkg::N_CFG-1:0] cfg_seg_tdo
);

  // ==========================================================
  // System domain: pin synchronisers
  logic sw_s1_ff, sw_s2_ff, pr_s1_ff, pr_s2_ff;
  logic [1:0] fill_ff;
  logic captured_ff, mode_cfg_ff, usb_allow_ff;
  logic [31:0] rdata_ff;

  always_ff @(posedge clk_sys) begin
    sw_s1_ff <= cfg_switch_on;
    sw_s2_ff <= sw_s1_ff;
    pr_s1_ff <= bb_probe_present;
    pr_s2_ff <= pr_s1_ff;
  end

  // ==========================================================
  // Mode capture: taken once after the synchroniser has filled
  wire take_mode = !captured_ff && (fill_ff == jtag_route_pkg::SYNC_FILL);
  wire [1:0] nxt_fill = (fill_ff == jtag_route_pkg::SYNC_FILL) ?
                        fill_ff : fill_ff + 2'h1;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fill_ff <= 2'h0;
      captured_ff <= 1'h0;
      mode_cfg_ff <= 1'h0;
    end else begin
      fill_ff <= nxt_fill;
      if (take_mode) begin
        // Later switch moves are ignored until power is cycled
        captured_ff <= 1'h1;
        mode_cfg_ff <= sw_s2_ff;
      end
    end
  end

  // ==========================================================
  // Panel outputs and USB port enable
  wire nxt_usb_en = !pr_s2_ff && usb_allow_ff;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      led_front_ff <= 1'h0;
      led_tile_ff <= 1'h0;
      fpga_flash_load_ff <= 1'h1;
      usb_cfg_en_ff <= 1'h0;
    end else begin
      led_front_ff <= mode_cfg_ff;
      led_tile_ff <= mode_cfg_ff;
      fpga_flash_load_ff <= !mode_cfg_ff;
      usb_cfg_en_ff <= nxt_usb_en;
    end
  end

  // ==========================================================
  // Register port
  wire hit_status = (reg_addr == jtag_route_pkg::ADDR_STATUS);
  wire hit_ctrl = (reg_addr == jtag_route_pkg::ADDR_CTRL);
  wire [31:0] status_word =
    (32'(mode_cfg_ff) << jtag_route_pkg::ST_MODE_CFG) |
    (32'(pr_s2_ff) << jtag_route_pkg::ST_PROBE) |
    (32'(usb_cfg_en_ff) << jtag_route_pkg::ST_USB_EN) |
    (32'(captured_ff) << jtag_route_pkg::ST_CAPTURED);
  wire [31:0] ctrl_word = 32'(usb_allow_ff) << jtag_route_pkg::CT_USB_ALLOW;
  wire [31:0] nxt_rdata = !reg_rd ? 32'h0000_0000 :
                          hit_status ? status_word :
                          hit_ctrl ? ctrl_word : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      usb_allow_ff <= jtag_route_pkg::CTRL_USB_ALLOW_RST;
      rdata_ff <= 32'h0000_0000;
    end else begin
      if (reg_wr && hit_ctrl) begin
        usb_allow_ff <= reg_wdata[jtag_route_pkg::CT_USB_ALLOW];
      end
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ==========================================================
  // Crossing into the link domain: quasi-static levels, two flops each
  logic rst_t1_ff, rst_t2_ff;
  logic mode_t1_ff, mode_t2_ff;
  logic bb_t1_ff, bb_t2_ff;
  logic usb_t1_ff, usb_t2_ff;

  always_ff @(posedge tck_link) begin
    rst_t1_ff <= sys_rst;
    rst_t2_ff <= rst_t1_ff;
    mode_t1_ff <= mode_cfg_ff;
    mode_t2_ff <= mode_t1_ff;
    bb_t1_ff <= pr_s2_ff;
    bb_t2_ff <= bb_t1_ff;
    usb_t1_ff <= usb_cfg_en_ff;
    usb_t2_ff <= usb_t1_ff;
  end

  // ==========================================================
  // Link domain: source selection
  wire cfg_m = mode_t2_ff;
  wire src_bb = bb_t2_ff;
  wire src_usb = !bb_t2_ff && usb_t2_ff;
  // Baseboard feeds only the config chain
  wire jtag_route_pkg::jtag_s cfg_src = src_bb ? bb_in :
                                        src_usb ? usb_in :
                                        jtag_route_pkg::JTAG_IDLE;

  // Each hop is retimed on the link clock, so every segment adds one
  // extra bit of chain length; debug software must allow for it.
  jtag_route_pkg::jtag_s [jtag_route_pkg::N_DBG-1:0] nxt_dbg;
  jtag_route_pkg::jtag_s [jtag_route_pkg::N_CFG-1:0] nxt_cfg;

  genvar gi;
  generate
    for (gi = 0; gi < jtag_route_pkg::N_DBG; gi++) begin : g_dbg
      if (gi == 0) begin : g_first
        // Only the rear-panel debugger drives this chain
        assign nxt_dbg[gi] = cfg_m ? jtag_route_pkg::JTAG_IDLE :
                             dbg_in;
      end else begin : g_next
        // Config mode parks the debug units, dropping the cpu unit
        wire jtag_route_pkg::jtag_s hop = '{tms: dbg_in.tms,
                                           tdi: dbg_seg_tdo[gi-1]};
        assign nxt_dbg[gi] = cfg_m ? jtag_route_pkg::JTAG_IDLE :
                             hop;
      end
    end
    for (gi = 0; gi < jtag_route_pkg::N_CFG; gi++) begin : g_cfg
      if (gi == 0) begin : g_first
        // Debugger never selected here; analyzer uses the tile in debug
        assign nxt_cfg[gi] = cfg_m ? cfg_src : ela_in;
      end else begin : g_next
        wire jtag_route_pkg::jtag_s hop = '{tms: cfg_src.tms,
                                           tdi: cfg_seg_tdo[gi-1]};
        assign nxt_cfg[gi] = cfg_m ? hop :
                             jtag_route_pkg::JTAG_IDLE;
        a_cfg_hop: assert property (
          @(posedge tck_link) disable iff (rst_t2_ff)
          !rst_t2_ff && cfg_m |=>
            cfg_seg_ff[gi].tdi == $past(cfg_seg_tdo[gi-1]))
          else $error("config chain hop out of order");
        a_cfg_parked: assert property (
          @(posedge tck_link) disable iff (rst_t2_ff)
          !cfg_m |=> cfg_seg_ff[gi] == jtag_route_pkg::JTAG_IDLE)
          else $error("config segment active in debug mode");
      end
    end
  endgenerate

  wire cfg_tdo = cfg_seg_tdo[jtag_route_pkg::CFG_CPU_BSCAN];
  // Debug chain ends at the processor debug unit
  wire nxt_dbg_tdo = !cfg_m && dbg_seg_tdo[jtag_route_pkg::DBG_CPU];
  wire nxt_bb_tdo = cfg_m && src_bb && cfg_tdo;
  wire nxt_usb_tdo = cfg_m && src_usb && cfg_tdo;
  wire nxt_ela_tdo = !cfg_m && cfg_seg_tdo[jtag_route_pkg::CFG_TILE];

  always_ff @(posedge tck_link) begin
    if (rst_t2_ff) begin
      dbg_seg_ff <= {jtag_route_pkg::N_DBG{jtag_route_pkg::JTAG_IDLE}};
      cfg_seg_ff <= {jtag_route_pkg::N_CFG{jtag_route_pkg::JTAG_IDLE}};
      dbg_tdo_ff <= 1'h0;
      bb_tdo_ff <= 1'h0;
      usb_tdo_ff <= 1'h0;
      ela_tdo_ff <= 1'h0;
    end else begin
      dbg_seg_ff <= nxt_dbg;
      cfg_seg_ff <= nxt_cfg;
      dbg_tdo_ff <= nxt_dbg_tdo;
      bb_tdo_ff <= nxt_bb_tdo;
      usb_tdo_ff <= nxt_usb_tdo;
      ela_tdo_ff <= nxt_ela_tdo;
    end
  end

  // ==========================================================
  // Checks, system domain
  a_mode_held: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    captured_ff |=> $stable(mode_cfg_ff) && captured_ff)
    else $error("mode changed after capture");

  a_default_debug: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    take_mode && !sw_s2_ff |=> !mode_cfg_ff ##1 !led_front_ff)
    else $error("switch off did not give debug mode");

  a_led_follows: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    $past(!sys_rst) |-> led_front_ff == $past(mode_cfg_ff)
      && led_tile_ff == led_front_ff)
    else $error("mode led does not follow mode");

  a_flash_load: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !mode_cfg_ff [*2] |-> fpga_flash_load_ff)
    else $error("debug mode without flash load");

  a_usb_blocked: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    pr_s2_ff |=> !usb_cfg_en_ff)
    else $error("usb port enabled with probe present");

  a_status_read: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    reg_rd && hit_status |=> reg_rdata[0] == $past(mode_cfg_ff))
    else $error("status read lost mode bit");

  a_cfg_capture: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    take_mode && sw_s2_ff |=> mode_cfg_ff ##1 led_front_ff && led_tile_ff)
    else $error("switch on did not give config mode");

  a_led_off: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !mode_cfg_ff [*2] |-> !led_front_ff && !led_tile_ff)
    else $error("mode led lit in debug mode");

  // The release edge still loads reset values, so it is kept out here
  a_usb_enable: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !sys_rst && !pr_s2_ff && usb_allow_ff |=> usb_cfg_en_ff)
    else $error("usb port not enabled without probe");

  a_rdata_idle: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not cleared after read");

  // ==========================================================
  // Checks, link domain
  a_dbg_order: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    !cfg_m |=> dbg_seg_ff[jtag_route_pkg::DBG_SB].tdi ==
               $past(dbg_seg_tdo[jtag_route_pkg::DBG_TILE]))
    else $error("debug chain order broken");

  a_cpu_parked: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    cfg_m |=>
      dbg_seg_ff[jtag_route_pkg::DBG_CPU] == jtag_route_pkg::JTAG_IDLE)
    else $error("cpu debug unit not parked in config mode");

  a_ela_route: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    !rst_t2_ff && !cfg_m |=>
      cfg_seg_ff[jtag_route_pkg::CFG_TILE] == $past(ela_in))
    else $error("analyzer not routed to tile cfg chain");

  a_cfg_source: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    cfg_m && src_bb |=> cfg_seg_ff[jtag_route_pkg::CFG_TILE] ==
                        $past(bb_in))
    else $error("config chain not fed by baseboard");

  a_bscan_last: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    cfg_m && src_usb |=> usb_tdo_ff == $past(cfg_tdo))
    else $error("config chain tail not returned to usb");

  a_dbg_entry: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    !rst_t2_ff && !cfg_m |=>
      dbg_seg_ff[jtag_route_pkg::DBG_TILE] == $past(dbg_in))
    else $error("debugger not driving debug chain");

  a_dbg_tail: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    !rst_t2_ff && !cfg_m |=>
      dbg_tdo_ff == $past(dbg_seg_tdo[jtag_route_pkg::DBG_CPU]))
    else $error("debug return not taken from processor unit");

  a_dbg_quiet: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    cfg_m |=> !dbg_tdo_ff)
    else $error("debug return active in config mode");

  a_usb_source: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    !rst_t2_ff && cfg_m && src_usb |=>
      cfg_seg_ff[jtag_route_pkg::CFG_TILE] == $past(usb_in))
    else $error("config chain not fed by usb bridge");

  a_cfg_idle: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    cfg_m && !src_bb && !src_usb |=>
      cfg_seg_ff[jtag_route_pkg::CFG_TILE] == jtag_route_pkg::JTAG_IDLE)
    else $error("config chain driven with no source");

  a_bb_return: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    !rst_t2_ff && cfg_m && src_bb |=>
      bb_tdo_ff == $past(cfg_tdo) && !usb_tdo_ff)
    else $error("config chain tail not returned to baseboard");

  a_ela_return: assert property (
    @(posedge tck_link) disable iff (rst_t2_ff)
    !rst_t2_ff && !cfg_m |=>
      ela_tdo_ff == $past(cfg_seg_tdo[jtag_route_pkg::CFG_TILE]))
    else $error("analyzer return not taken from tile chain");

endmodule

// ===== tb/jtag_seg_model.sv
// Far-side scan segment model: each segment returns its TDI one TCK later
`timescale 1ns/1ps
module jtag_seg_model #(
  parameter int N = 1
) (
  input wire logic tck,
  input wire jtag_route_pkg::jtag_s [N-1:0] seg,
  output logic [N-1:0] tdo
);
  // ==========================================================
  // Bypass stage
  // A one-bit bypass per segment keeps chain delay easy to predict
  always_ff @(posedge tck) begin
    for (int i = 0; i < N; i++) begin
      tdo[i] <= seg[i].tdi;
    end
  end
endmodule

// ===== tb/tb_jtag_scan_path_router.sv
// Self-checking bench for the scan path router
`timescale 1ns/1ps
module tb_jtag_scan_path_router;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic tck_link = 1'h0;
  logic cfg_switch_on = 1'h0;
  logic bb_probe_present = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic led_front_ff, led_tile_ff, fpga_flash_load_ff, usb_cfg_en_ff;
  jtag_route_pkg::jtag_s dbg_in = jtag_route_pkg::JTAG_IDLE;
  jtag_route_pkg::jtag_s bb_in = jtag_route_pkg::JTAG_IDLE;
  jtag_route_pkg::jtag_s usb_in = jtag_route_pkg::JTAG_IDLE;
  jtag_route_pkg::jtag_s ela_in = jtag_route_pkg::JTAG_IDLE;
  logic dbg_tdo_ff, bb_tdo_ff, usb_tdo_ff, ela_tdo_ff;
  jtag_route_pkg::jtag_s [jtag_route_pkg::N_DBG-1:0] dbg_seg_ff;
  jtag_route_pkg::jtag_s [jtag_route_pkg::N_CFG-1:0] cfg_seg_ff;
  logic [jtag_route_pkg::N_DBG-1:0] dbg_seg_tdo;
  logic [jtag_route_pkg::N_CFG-1:0] cfg_seg_tdo;
  int miscompares = 0;
  int checks = 0;

  // ==========================================================
  // Clocks: link clock phase is deliberately unrelated
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    #1.7;
    forever #3 tck_link = ~tck_link;
  end

  jtag_scan_path_router DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .tck_link(tck_link), .cfg_switch_on(cfg_switch_on),
    .bb_probe_present(bb_probe_present), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .led_front_ff(led_front_ff),
    .led_tile_ff(led_tile_ff), .fpga_flash_load_ff(fpga_flash_load_ff),
    .usb_cfg_en_ff(usb_cfg_en_ff), .dbg_in(dbg_in),
    .dbg_tdo_ff(dbg_tdo_ff), .bb_in(bb_in), .bb_tdo_ff(bb_tdo_ff),
    .usb_in(usb_in), .usb_tdo_ff(usb_tdo_ff), .ela_in(ela_in),
    .ela_tdo_ff(ela_tdo_ff), .dbg_seg_ff(dbg_seg_ff),
    .dbg_seg_tdo(dbg_seg_tdo), .cfg_seg_ff(cfg_seg_ff),
    .cfg_seg_tdo(cfg_seg_tdo));
  jtag_seg_model #(.N(jtag_route_pkg::N_DBG)) u_dbg_segs (.tck(tck_link),
    .seg(dbg_seg_ff), .tdo(dbg_seg_tdo));
  jtag_seg_model #(.N(jtag_route_pkg::N_CFG)) u_cfg_segs (.tck(tck_link),
    .seg(cfg_seg_ff), .tdo(cfg_seg_tdo));

  // ==========================================================
  // Tasks
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                            input string m);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  // Link-side sources change just after a link clock edge
  task automatic drive_src(input logic d, input logic b, input logic u,
                           input logic e);
    @(posedge tck_link);
    dbg_in <= {1'h0, d};
    bb_in <= {1'h0, b};
    usb_in <= {1'h0, u};
    ela_in <= {1'h0, e};
    clks(10);
  endtask
  task automatic power_up(input logic sw);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    cfg_switch_on <= sw;
    clks(6);
    sys_rst <= 1'h0;
    clks(12);
  endtask

  initial begin
    #200us;
    miscompares++;
    complete_run;
  end

  // ==========================================================
  // Scenarios
  initial begin
    logic [31:0] rd;
    power_up(1'h0);
    reg_read(jtag_route_pkg::ADDR_STATUS, rd);
    check_bit(rd[jtag_route_pkg::ST_MODE_CFG], 1'h0, "debug mode");
    check_bit(rd[jtag_route_pkg::ST_CAPTURED], 1'h1, "captured");
    check_word(32'({led_front_ff, led_tile_ff}), 32'h0000_0000, "led");
    check_bit(fpga_flash_load_ff, 1'h1, "flash load");
    drive_src(1'h1, 1'h0, 1'h0, 1'h1);
    check_bit(dbg_seg_ff[jtag_route_pkg::DBG_TILE].tdi, 1'h1, "tile");
    check_bit(dbg_seg_ff[jtag_route_pkg::DBG_SB].tdi, 1'h1, "sb");
    check_bit(dbg_seg_ff[jtag_route_pkg::DBG_CPU].tdi, 1'h1, "cpu");
    check_bit(dbg_seg_ff[jtag_route_pkg::DBG_CPU].tms, 1'h0, "tms");
    check_bit(dbg_tdo_ff, 1'h1, "debugger return");
    check_bit(cfg_seg_ff[jtag_route_pkg::CFG_TILE].tdi, 1'h1, "ela");
    check_bit(ela_tdo_ff, 1'h1, "ela return");
    check_bit(cfg_seg_ff[jtag_route_pkg::CFG_CPU_BSCAN].tdi, 1'h0, "c");
    drive_src(1'h0, 1'h1, 1'h1, 1'h0);
    check_bit(dbg_seg_ff[jtag_route_pkg::DBG_TILE].tdi, 1'h0, "bb");
    check_bit(dbg_tdo_ff, 1'h0, "debugger return low");
    cfg_switch_on <= 1'h1;
    clks(10);
    reg_read(jtag_route_pkg::ADDR_STATUS, rd);
    check_bit(rd[jtag_route_pkg::ST_MODE_CFG], 1'h0, "mode held");
    check_bit(led_front_ff, 1'h0, "led held");
    power_up(1'h1);
    reg_read(jtag_route_pkg::ADDR_STATUS, rd);
    check_bit(rd[jtag_route_pkg::ST_MODE_CFG], 1'h1, "cfg mode");
    check_word(rd, 32'h0000_000D, "status cfg");
    check_word(32'({led_front_ff, led_tile_ff}), 32'h0000_0003, "led");
    check_bit(fpga_flash_load_ff, 1'h0, "jtag load");
    check_bit(usb_cfg_en_ff, 1'h1, "usb on");
    reg_read(jtag_route_pkg::ADDR_CTRL, rd);
    check_word(rd, 32'(jtag_route_pkg::CTRL_USB_ALLOW_RST), "ctrl rst");
    drive_src(1'h1, 1'h0, 1'h1, 1'h0);
    check_bit(cfg_seg_ff[jtag_route_pkg::CFG_TILE].tdi, 1'h1, "c0");
    check_bit(cfg_seg_ff[jtag_route_pkg::CFG_CPU_BSCAN].tdi, 1'h1, "c5");
    check_bit(cfg_seg_ff[jtag_route_pkg::CFG_CPU_BSCAN].tms, 1'h0, "t5");
    check_bit(usb_tdo_ff, 1'h1, "usb return");
    check_word(32'(dbg_seg_ff[jtag_route_pkg::DBG_CPU]),
               32'(jtag_route_pkg::JTAG_IDLE), "cpu debug idle");
    bb_probe_present <= 1'h1;
    clks(10);
    check_bit(usb_cfg_en_ff, 1'h0, "usb off");
    reg_read(jtag_route_pkg::ADDR_STATUS, rd);
    check_word(rd, 32'h0000_000B, "status probe");
    check_bit(cfg_seg_ff[jtag_route_pkg::CFG_CPU_BSCAN].tdi, 1'h0, "u");
    drive_src(1'h1, 1'h1, 1'h0, 1'h0);
    check_bit(cfg_seg_ff[jtag_route_pkg::CFG_CPU_BSCAN].tdi, 1'h1, "b");
    check_bit(bb_tdo_ff, 1'h1, "bb return");
    bb_probe_present <= 1'h0;
    reg_write(jtag_route_pkg::ADDR_CTRL, 32'h0000_0000);
    clks(4);
    check_bit(usb_cfg_en_ff, 1'h0, "usb gated");
    reg_write(jtag_route_pkg::ADDR_STATUS, 32'hFFFF_FFF0);
    reg_read(jtag_route_pkg::ADDR_STATUS, rd);
    check_word(rd, 32'h0000_0009, "status ro");
    reg_read(8'h0C, rd);
    check_word(rd, 32'h0000_0000, "unmapped");
    reg_write(jtag_route_pkg::ADDR_CTRL, 32'h0000_0001);
    clks(4);
    check_bit(usb_cfg_en_ff, 1'h1, "usb back");
    complete_run;
  end
endmodule
